// >>> design/cbu_branch.v
// conditional relative branch unit
`include "cbu_map.vh"
module cbu_branch #(
   parameter PC_W  = 16,
   parameter OFS_W = 7
) (
   input  wire                 clk,
   input  wire                 reset_n,
   input  wire                 issue,
   input  wire [2:0]           op_code,
   input  wire [2:0]           flag_index,
   input  wire [OFS_W-1:0]     offset,
   input  wire [PC_W-1:0]      pc_in,
   input  wire [7:0]           status_register,
   output reg                  pc_load_r,
   output reg  [PC_W-1:0]      pc_target_r,
   output reg                  busy_r,
   output reg                  done_r,
   output reg                  taken_r,
   output reg  [7:0]           status_out_r
);
   //----------------------------------------
   // states
   //----------------------------------------
   localparam [1:0] ST_IDLE   = 2'h1;
   localparam [1:0] ST_BRANCH = 2'h2;

   reg  [1:0]      state_r;
   reg  [1:0]      state_nxt;
   reg  [PC_W-1:0] target_nxt;
   reg  [PC_W-1:0] pc_target_nxt;
   reg             pc_load_nxt;
   reg             busy_nxt;
   reg             done_nxt;
   reg             taken_nxt;
   reg  [7:0]      status_out_nxt;
   wire            take;
   wire            accept;
   wire [PC_W-1:0] pc_step;
   wire [PC_W-1:0] ofs_wide;

   //----------------------------------------
   // arithmetic and state-test helpers
   //----------------------------------------
   // offset sign-extended to the pc width
   function [PC_W-1:0] sext_offset;
      input [OFS_W-1:0] ofs;
      begin
         sext_offset = {{(PC_W-OFS_W){ofs[OFS_W-1]}}, ofs};
      end
   endfunction

   // next sequential word, wraps at the top
   function [PC_W-1:0] next_word;
      input [PC_W-1:0] pc;
      begin
         next_word = pc + {{(PC_W-1){1'h0}}, 1'h1};
      end
   endfunction

   // one-hot state test
   function in_state;
      input [1:0] cur;
      input [1:0] want;
      begin
         in_state = |(cur & want);
      end
   endfunction

   //----------------------------------------
   // condition evaluation
   //----------------------------------------
   cbu_cond_eval u_eval (
      .op_code         (op_code),
      .flag_index      (flag_index),
      .status_register (status_register),
      .take            (take)
   );

   //----------------------------------------
   // acceptance and target
   //----------------------------------------
   // issue only seen while idle; the busy cycle drops it
   assign accept   = issue & in_state(state_r, ST_IDLE);
   assign pc_step  = next_word(pc_in);
   assign ofs_wide = sext_offset(offset);

   always @* begin
      target_nxt = pc_step + ofs_wide;
   end

   //----------------------------------------
   // next state
   //----------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (accept && take) begin
               state_nxt = ST_BRANCH;
            end
         end
         ST_BRANCH: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   //----------------------------------------
   // next pulse values
   //----------------------------------------
   always @* begin
      pc_load_nxt = 1'h0;
      busy_nxt    = 1'h0;
      done_nxt    = 1'h0;
      case (state_r)
         ST_IDLE: begin
            if (accept) begin
               if (take) begin
                  pc_load_nxt = 1'h1;
                  busy_nxt    = 1'h1;
               end else begin
                  done_nxt    = 1'h1;
               end
            end
         end
         ST_BRANCH: begin
            done_nxt = 1'h1;
         end
         default: begin
            done_nxt = 1'h0;
         end
      endcase
   end

   //----------------------------------------
   // next held values, and the flags passed through
   //----------------------------------------
   always @* begin
      taken_nxt      = taken_r;
      pc_target_nxt  = pc_target_r;
      status_out_nxt = status_register;
      case (state_r)
         ST_IDLE: begin
            if (accept) begin
               taken_nxt = take;
               if (take) begin
                  pc_target_nxt = target_nxt;
               end else begin
                  pc_target_nxt = pc_step;
               end
            end
         end
         ST_BRANCH: begin
            taken_nxt = taken_r;
         end
         default: begin
            taken_nxt = 1'h0;
         end
      endcase
   end

   //----------------------------------------
   // state register
   //----------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   //----------------------------------------
   // output registers
   //----------------------------------------
   // load strobe to the program counter
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_load_r <= 1'h0;
      end else begin
         pc_load_r <= pc_load_nxt;
      end
   end

   // branch target or next word
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_target_r <= `CBU_PC_RESET;
      end else begin
         pc_target_r <= pc_target_nxt;
      end
   end

   // second cycle of a taken branch
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_r <= 1'h0;
      end else begin
         busy_r <= busy_nxt;
      end
   end

   // end of instruction
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done_r <= 1'h0;
      end else begin
         done_r <= done_nxt;
      end
   end

   // result of the last accepted issue
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         taken_r <= 1'h0;
      end else begin
         taken_r <= taken_nxt;
      end
   end

   // flags pass through untouched
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_out_r <= `CBU_STATUS_REGISTER_RESET;
      end else begin
         status_out_r <= status_out_nxt;
      end
   end
endmodule // cbu_branch

// >>> common/cbu_map.vh
// constants for the conditional branch unit
`ifndef CBU_MAP_VH
`define CBU_MAP_VH
// operation codes on op_code
`define CBU_OP_FLAG_SET   3'h0
`define CBU_OP_FLAG_CLEAR 3'h1
`define CBU_OP_EQUAL      3'h2
`define CBU_OP_NOT_EQUAL  3'h3
`define CBU_OP_CARRY_SET  3'h4
`define CBU_OP_CARRY_CLR  3'h5
// status register bit positions
`define CBU_BIT_CARRY     3'h0
`define CBU_BIT_ZERO      3'h1
// reset values
`define CBU_PC_RESET      16'h0000
`define CBU_STATUS_REGISTER_RESET    8'h00
`endif

// >>> design/cbu_cond_eval.v
// condition evaluation for the conditional branch unit
`include "cbu_map.vh"
module cbu_cond_eval (
   input  wire [2:0] op_code,
   input  wire [2:0] flag_index,
   input  wire [7:0] status_register,
   output reg        take
);
   always @* begin
      case (op_code)
         `CBU_OP_FLAG_SET:   take = status_register[flag_index];
         `CBU_OP_FLAG_CLEAR: take = ~status_register[flag_index];
         `CBU_OP_EQUAL:      take = status_register[`CBU_BIT_ZERO];
         `CBU_OP_NOT_EQUAL:  take = ~status_register[`CBU_BIT_ZERO];
         `CBU_OP_CARRY_SET:  take = status_register[`CBU_BIT_CARRY];
         `CBU_OP_CARRY_CLR:  take = ~status_register[`CBU_BIT_CARRY];
         default:            take = 1'b0;
      endcase
   end
endmodule // cbu_cond_eval

// >>> tb/cbu_branch_sva.sv
// assertions for the branch unit
module cbu_branch_sva #(parameter PC_W = 16, OFS_W = 7) (input wire clk, reset_n, issue,
   input wire [2:0] op_code, flag_index, input wire [OFS_W-1:0] offset,
   input wire [PC_W-1:0] pc_in, pc_target_r, input wire [7:0] status_register, status_out_r,
   input wire pc_load_r, busy_r, done_r, taken_r);
   timeunit 1ns; timeprecision 1ns;
   wire a = issue && !busy_r;
   wire s = status_register[flag_index];
   wire z = status_register[1];
   wire c = status_register[0];
   wire [PC_W-1:0] t0 = pc_in + 1'b1;
   wire [PC_W-1:0] t1 = t0 + {{(PC_W-OFS_W){offset[OFS_W-1]}}, offset};
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_flag_set: assert property (a && op_code == 3'h0 |=> taken_r == $past(s)) else $error("set");
   chk_flag_clr: assert property (a && op_code == 3'h1 |=> taken_r != $past(s)) else $error("clr");
   chk_zero_set: assert property (a && op_code == 3'h2 |=> taken_r == $past(z)) else $error("eq");
   chk_zero_clr: assert property (a && op_code == 3'h3 |=> taken_r != $past(z)) else $error("ne");
   chk_carry_set: assert property (a && op_code == 3'h4 |=> taken_r == $past(c)) else $error("cs");
   chk_carry_clr: assert property (a && op_code == 3'h5 |=> taken_r != $past(c)) else $error("cc");
   chk_flags_kept: assert property ($past(reset_n, 2) |-> status_out_r == $past(status_register))
      else $error("flags");
   chk_cycle_count: assert property (a |=> if (taken_r) (pc_load_r && busy_r ##1 done_r && !busy_r)
      else (done_r && !pc_load_r)) else $error("cycles");
   chk_target_sum: assert property (a |=> pc_target_r == (taken_r ? $past(t1) : $past(t0)))
      else $error("target");
   cover property (a && op_code == 3'h0 ##1 taken_r);
   cover property (a ##1 busy_r && issue);
   cover property (done_r ##1 done_r);
endmodule // cbu_branch_sva
bind cbu_branch cbu_branch_sva #(.PC_W(PC_W), .OFS_W(OFS_W)) chk_i (.*);

// >>> tb/cbu_core_model.sv
// core side: program counter follows the unit's result
module cbu_core_model (input wire clk, reset_n, done_r, input wire [15:0] pc_target_r,
   output logic [15:0] pc_in);
   timeunit 1ns; timeprecision 1ns;
   always @(negedge clk or negedge reset_n)
      if (!reset_n) pc_in <= 16'h0000;
      else if (done_r) pc_in <= pc_target_r;
endmodule // cbu_core_model

// >>> tb/tb_conditional_branch_unit.sv
// bench for the branch unit
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_conditional_branch_unit;
   timeunit 1ns; timeprecision 1ns;
   logic clk, reset_n, issue, pc_load_r, busy_r, done_r, taken_r, e;
   logic [2:0] op_code, flag_index;
   logic [6:0] offset;
   logic [7:0] status_register, status_out_r;
   logic [15:0] pc_in, pc_target_r, t;
   int fails, num_checks;
   cbu_branch uut (.*);
   cbu_core_model core_i (.*);
   always #25 clk = ~clk;
   function automatic logic want(logic [2:0] o, f, logic [7:0] s);
      case (o)
         3'h0: return s[f];
         3'h1: return !s[f];
         3'h2: return s[1];
         3'h3: return !s[1];
         3'h4: return s[0];
         3'h5: return !s[0];
         default: return 1'b0;
      endcase
   endfunction
   task automatic go(logic [2:0] o, f, logic [6:0] k, logic [7:0] s);
      @(negedge clk);
      e = want(o, f, s);
      t = pc_in + (e ? {{9{k[6]}}, k} : 16'h0000) + 16'h0001;
      {issue, op_code, flag_index, offset, status_register} = {1'b1, o, f, k, s};
      @(negedge clk);
      issue = e; // held into the busy cycle, must be ignored
      `CHK("taken", e, taken_r)
      `CHK("target", t, pc_target_r)
      `CHK("flags", s, status_out_r)
      `CHK("load", e, pc_load_r)
      `CHK("busy", e, busy_r)
      if (e) begin
         @(negedge clk);
         issue = 0;
      end
      `CHK("done", 1'b1, done_r)
      $display("test op %0d ends", o);
   endtask
   task automatic complete_run;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      {clk, reset_n, issue, op_code, flag_index, offset, status_register} = '0;
      void'($urandom(32'h4120E7E1));
      repeat (20) @(negedge clk);
      reset_n = 1;
      for (int i = 0; i < 8; i++) go(3'(i), 3'(i), 7'h3F, 8'hAA);
      for (int i = 0; i < 8; i++) go(3'(i), 3'(7 - i), 7'h40, 8'h55);
      repeat (300) go(3'($urandom), 3'($urandom), 7'($urandom), 8'($urandom));
      complete_run;
   end
   initial begin
      #250000;
      fails++;
      complete_run;
   end
endmodule // tb_conditional_branch_unit
